// file: rtl/sfcr_loader.sv
// Summary of operation
// - Device generates link clock from internal oscillator
// - Variant chooses read command and dummy count
// - Variant 111: fast read, one dummy
// - Variant 101: plain read, no dummy
// - Variant 110: array read, four dummies
// - Pins wire to flash data, select, clock
// - Write-protect and hold never driven or used
// - Straps sampled when init indicator rises
// - Straps become user I/O after done
// - Pull-ups enabled while strap low, until done
// - Daisy-chain output actively driven during load
`timescale 1ns/100ps
`default_nettype none
module sfcr_loader
  import sfcr_pkg::*;
#(
  parameter logic [7:0] SCK_HALF = SCK_HALF_DEF,
  parameter logic [23:0] START_ADDR = START_ADDR_DEF,
  parameter int DATA_BITS = 32
) (
  // System
  input wire logic clk,
  input wire logic rst,
  // Init and completion
  input wire logic init_release,
  input wire logic load_done,
  output logic init_q,
  output logic done_q,
  output logic bad_variant_q,
  // Strap pins, raw from outside
  input wire logic [2:0] mode_strap,
  input wire logic [2:0] flash_variant_strap,
  input wire logic pullup_disable_strap,
  // Flash link
  input wire logic flash_miso,
  output var sfcr_link_out_t link_q,
  output logic daisy_out_q,
  // Configuration data stream
  output logic [7:0] data_byte_q,
  output logic data_valid_q,
  // I/O control
  output logic io_pullup_en,
  output logic straps_user_io,
  output var sfcr_straps_t straps_q
);
  typedef enum {ST_IDLE, ST_HDR, ST_DUMMY, ST_DATA, ST_END} sfcr_state_t;

  // Pin synchronisers
  logic [6:0] strap_m_q, strap_s_q;
  logic [1:0] miso_q, rel_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_m_q <= 7'h00;
      strap_s_q <= 7'h00;
      miso_q <= 2'h0;
      rel_q <= 2'h0;
    end else begin
      strap_m_q <= {mode_strap, flash_variant_strap, pullup_disable_strap};
      strap_s_q <= strap_m_q;
      miso_q <= {miso_q[0], flash_miso};
      rel_q <= {rel_q[0], init_release};
    end
  end

  sfcr_state_t st_q, st_d;
  logic [31:0] sh_q, sh_d;
  logic [5:0] bit_q, bit_d;
  logic [2:0] dum_q, dum_d;
  logic init_d, done_d, bad_d, vld_d, cs_n_d, mosi_d;
  logic [7:0] byte_d;
  sfcr_straps_t straps_d;
  sfcr_read_cfg_t rcfg;
  logic run, sck, rise, fall;

  // Link clock divider, runs only while selected
  assign run = (st_q == ST_HDR) || (st_q == ST_DUMMY) || (st_q == ST_DATA);
  sfcr_clk_gen #(.HALF(SCK_HALF)) u_clk (
    .clk(clk),
    .rst(rst),
    .run(run),
    .sck_q(sck),
    .rise(rise),
    .fall(fall)
  );

  // Variant decode; reserved codes refuse to start
  always_comb begin
    rcfg = '0;
    case (straps_q.variant)
      VAR_FAST: rcfg = '{1'b1, CMD_FAST, DUMMY_FAST};
      VAR_PLAIN: rcfg = '{1'b1, CMD_PLAIN, DUMMY_PLAIN};
      VAR_ARRAY: rcfg = '{1'b1, CMD_ARRAY, DUMMY_ARRAY};
      default: rcfg = '0;
    endcase
  end

  // Sequencer: MOSI changes on falling, flash data sampled on rising edge
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    bit_d = bit_q;
    dum_d = dum_q;
    init_d = init_q;
    done_d = done_q;
    bad_d = bad_variant_q;
    vld_d = 1'b0;
    byte_d = data_byte_q;
    cs_n_d = link_q.flash_select_n;
    mosi_d = link_q.mosi;
    straps_d = straps_q;
    case (st_q)
      ST_IDLE: begin
        if (rel_q[1] && !init_q && !done_q) begin
          init_d = 1'b1;
          straps_d = strap_s_q;
        end else if (init_q && !done_q) begin
          if (straps_q.mode != MODE_SPI || !rcfg.valid) begin
            // Only a serial load can meet a reserved code; other modes just finish
            bad_d = (straps_q.mode == MODE_SPI);
            st_d = ST_END;
          end else begin
            sh_d = {rcfg.cmd, START_ADDR};
            mosi_d = rcfg.cmd[7];
            cs_n_d = 1'b0;
            bit_d = 6'h00;
            dum_d = rcfg.dummy;
            st_d = ST_HDR;
          end
        end
      end
      ST_HDR: begin
        if (fall) begin
          if (bit_q == 6'(HDR_BITS - 1)) begin
            bit_d = 6'h00;
            mosi_d = 1'b0;
            st_d = (dum_q == 3'h0) ? ST_DATA : ST_DUMMY;
          end else begin
            bit_d = bit_q + 6'h01;
            sh_d = {sh_q[30:0], 1'b0};
            mosi_d = sh_q[30];
          end
        end
      end
      ST_DUMMY: begin
        if (fall) begin
          if (bit_q == 6'h07) begin
            bit_d = 6'h00;
            dum_d = dum_q - 3'h1;
            if (dum_q == 3'h1) begin
              st_d = ST_DATA;
            end
          end else begin
            bit_d = bit_q + 6'h01;
          end
        end
      end
      ST_DATA: begin
        // End only in a low phase, so the last high pulse is never clipped
        if (load_done && !sck && !rise) begin
          cs_n_d = 1'b1;
          st_d = ST_END;
        end else if (rise) begin
          sh_d = {sh_q[30:0], miso_q[1]};
          if (bit_q[2:0] == 3'h7) begin
            byte_d = {sh_q[6:0], miso_q[1]};
            vld_d = 1'b1;
          end
          bit_d = {3'h0, bit_q[2:0] + 3'h1};
        end
      end
      ST_END: begin
        cs_n_d = 1'b1;
        done_d = !bad_variant_q;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      sh_q <= 32'h0;
      bit_q <= 6'h00;
      dum_q <= 3'h0;
      init_q <= 1'b0;
      done_q <= 1'b0;
      bad_variant_q <= 1'b0;
      data_valid_q <= 1'b0;
      data_byte_q <= 8'h00;
      link_q <= '{1'b0, 1'b1, 1'b0};
      straps_q <= '0;
      daisy_out_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      dum_q <= dum_d;
      init_q <= init_d;
      done_q <= done_d;
      bad_variant_q <= bad_d;
      data_valid_q <= vld_d;
      data_byte_q <= byte_d;
      link_q <= '{sck, cs_n_d, mosi_d};
      straps_q <= straps_d;
      daisy_out_q <= 1'b1;
    end
  end

  // Pull-ups from reset until done; the strap is held steady by the board
  assign io_pullup_en = !done_q && !strap_s_q[0];
  assign straps_user_io = done_q;
  // No write-protect or hold port exists: the flash controls stay free
endmodule
`default_nettype wire

// file: pkg/sfcr_pkg.sv
package sfcr_pkg;
  // Configuration mode code selecting serial flash load
  localparam logic [2:0] MODE_SPI = 3'h1;
  // Variant codes
  localparam logic [2:0] VAR_FAST = 3'h7;
  localparam logic [2:0] VAR_PLAIN = 3'h5;
  localparam logic [2:0] VAR_ARRAY = 3'h6;
  // Read commands
  localparam logic [7:0] CMD_FAST = 8'h0b;
  localparam logic [7:0] CMD_PLAIN = 8'h03;
  localparam logic [7:0] CMD_ARRAY = 8'he8;
  // Dummy byte counts
  localparam logic [2:0] DUMMY_FAST = 3'h1;
  localparam logic [2:0] DUMMY_PLAIN = 3'h0;
  localparam logic [2:0] DUMMY_ARRAY = 3'h4;
  // Field layout of the outgoing header
  localparam int CMD_BITS = 8;
  localparam int ADDR_BITS = 24;
  localparam int HDR_BITS = CMD_BITS + ADDR_BITS;
  // Link clock half period in system clocks
  localparam logic [7:0] SCK_HALF_DEF = 8'h04;
  // Default value of the start address
  localparam logic [23:0] START_ADDR_DEF = 24'h000000;

  // Sampled straps
  typedef struct packed {
    logic [2:0] mode;
    logic [2:0] variant;
    logic pullup_disable;
  } sfcr_straps_t;

  // Flash pins, outputs from the device
  typedef struct packed {
    logic config_clock_out;
    logic flash_select_n;
    logic mosi;
  } sfcr_link_out_t;

  // Read setup decoded from variant
  typedef struct packed {
    logic valid;
    logic [7:0] cmd;
    logic [2:0] dummy;
  } sfcr_read_cfg_t;
endpackage

// file: rtl/sfcr_clk_gen.sv
`timescale 1ns/100ps
`default_nettype none
module sfcr_clk_gen
  import sfcr_pkg::*;
#(
  parameter logic [7:0] HALF = SCK_HALF_DEF
) (
  // System
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic run,
  // Link clock and edge strobes
  output logic sck_q,
  output logic rise,
  output logic fall
);
  logic [7:0] cnt_q, cnt_d;
  logic sck_d;
  logic wrap;

  // Divider from the internal clock; idles low when stopped
  assign wrap = (cnt_q == HALF - 8'h01);
  always_comb begin
    cnt_d = cnt_q;
    sck_d = sck_q;
    if (!run) begin
      cnt_d = 8'h00;
      sck_d = 1'b0;
    end else if (wrap) begin
      cnt_d = 8'h00;
      sck_d = ~sck_q;
    end else begin
      cnt_d = cnt_q + 8'h01;
    end
  end
  assign rise = run && wrap && !sck_q;
  assign fall = run && wrap && sck_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
      sck_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sck_q <= sck_d;
    end
  end
endmodule
`default_nettype wire

// file: verification/sfcr_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module sfcr_flash_model (
  // Flash pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic [2:0] dummy,
  output logic so
);
  logic [31:0] hdr;
  int n;
  int k;
  logic [7:0] b;
  // Board-side flash controls, held high through the whole load
  logic hold_n = 1'b1;
  logic wp_n = 1'b1;
  logic reset_n = 1'b1;
  wire logic pins_ok = hold_n && wp_n && reset_n;
  initial so = 0;
  // New frame on select
  always @(negedge cs_n) n = 0;
  // Header taken on rising edges
  always @(posedge sck) if (!cs_n && pins_ok) begin
    if (n < 32) hdr = {hdr[30:0], si};
    n++;
  end
  // Data after dummies, on falling edges
  always @(negedge sck) if (!cs_n && pins_ok && n >= 32 + 8 * dummy) begin
    k = n - 32 - 8 * dummy;
    b = 8'h3c + 8'(k / 8);
    so = b[7 - k % 8];
  end
  // Released line must not keep its last level
  always @(posedge cs_n) so = ~so;
endmodule
`default_nettype wire

// file: verification/sfcr_loader_props.sv
`timescale 1ns/100ps
`default_nettype none
module sfcr_loader_props
  import sfcr_pkg::*;
(
  // Watched ports
  input wire logic clk,
  input wire logic rst,
  input wire logic init_q,
  input wire logic done_q,
  input wire logic bad_variant_q,
  input wire sfcr_link_out_t link_q,
  input wire logic daisy_out_q,
  input wire logic data_valid_q,
  input wire logic io_pullup_en,
  input wire logic straps_user_io,
  input wire sfcr_straps_t straps_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Completion and straps
  done_hold_a: assert property (done_q |=> done_q)
    else $error("done dropped");
  user_io_a: assert property (straps_user_io == done_q &&
    (!done_q || (link_q.flash_select_n && !io_pullup_en)))
    else $error("user io wrong");
  pullup_done_a: assert property (io_pullup_en |-> !done_q)
    else $error("pullup after done");
  strap_hold_a: assert property (init_q && $past(init_q) |-> $stable(straps_q))
    else $error("straps moved");
  // Link activity
  idle_pre_a: assert property (!init_q |-> link_q.flash_select_n)
    else $error("select before init");
  sel_mode_a: assert property (!link_q.flash_select_n |-> straps_q.mode == MODE_SPI)
    else $error("select in other mode");
  bad_idle_a: assert property (bad_variant_q |-> link_q.flash_select_n && !done_q)
    else $error("reserved code loaded");
  sck_high_a: assert property ($rose(link_q.config_clock_out) |-> link_q.config_clock_out[*4])
    else $error("clock high phase short");
  valid_pulse_a: assert property (data_valid_q |=> !data_valid_q)
    else $error("valid too long");
  daisy_drive_a: assert property (!$past(rst) |-> daisy_out_q)
    else $error("daisy not driven");
  c_data: cover property (data_valid_q);
  c_bad: cover property (bad_variant_q);
  c_done: cover property ($rose(done_q));
endmodule
bind sfcr_loader sfcr_loader_props u_props (.clk(clk), .rst(rst), .init_q(init_q),
  .done_q(done_q), .bad_variant_q(bad_variant_q), .link_q(link_q), .daisy_out_q(daisy_out_q),
  .data_valid_q(data_valid_q), .io_pullup_en(io_pullup_en), .straps_user_io(straps_user_io),
  .straps_q(straps_q));
`default_nettype wire

// file: verification/tb_spi_flash_config_reader.sv
`timescale 1ns/100ps
`default_nettype none
module tb_spi_flash_config_reader;
  import sfcr_pkg::*;
  logic clk = 0, rst = 1, init_release = 0, load_done = 0, pud = 0;
  logic [2:0] mode = 3'h1, vstrap = 3'h7, dum = 3'h1;
  logic miso, init_q, done_q, bad_q, daisy, dv, pue, uio;
  logic [7:0] db;
  sfcr_link_out_t lk;
  sfcr_straps_t st;
  int n_fail = 0, checks = 0, cyc = 0;
  sfcr_loader uut (.clk(clk), .rst(rst), .init_release(init_release), .load_done(load_done),
    .init_q(init_q), .done_q(done_q), .bad_variant_q(bad_q), .mode_strap(mode),
    .flash_variant_strap(vstrap), .pullup_disable_strap(pud), .flash_miso(miso),
    .link_q(lk), .daisy_out_q(daisy), .data_byte_q(db), .data_valid_q(dv),
    .io_pullup_en(pue), .straps_user_io(uio), .straps_q(st));
  sfcr_flash_model fl (.sck(lk.config_clock_out), .cs_n(lk.flash_select_n), .si(lk.mosi),
    .dummy(dum), .so(miso));
  initial forever #5 clk = ~clk;
  // Hang guard
  always @(posedge clk) if (++cyc == 40000) begin
    n_fail++;
    give_verdict();
  end
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Reset, set straps, let init rise
  task automatic start(logic [2:0] m, logic [2:0] v, logic p);
    rst = 1; load_done = 0; init_release = 0; mode = m; vstrap = v; pud = p;
    tick(12); rst = 0; tick(2); init_release = 1; tick(8);
    mode = ~m; vstrap = ~v; // Late strap moves must be ignored
  endtask
  // One load with three data bytes
  task automatic rd(logic [2:0] v, logic [7:0] cmd, logic [2:0] d, logic p);
    int k;
    dum = d;
    start(MODE_SPI, v, p);
    chk("straps", st, {MODE_SPI, v, p});
    chk("pullup", pue, !p);
    chk("daisy", daisy, 1);
    for (int i = 0; i < 3; i++) begin
      k = 0;
      while (dv !== 1'b1 && k++ < 3000) tick(1);
      chk("byte", db, 8'h3c + 8'(i));
      tick(1);
    end
    chk("header", fl.hdr, {cmd, START_ADDR_DEF});
    load_done = 1;
    tick(12);
    chk("done", {done_q, uio, lk.flash_select_n}, 3'h7);
    chk("pullup off", pue, 0);
    $display("test read %h done", v);
  endtask
  task automatic give_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    rd(VAR_FAST, CMD_FAST, DUMMY_FAST, 1'b0);
    rd(VAR_PLAIN, CMD_PLAIN, DUMMY_PLAIN, 1'b0);
    rd(VAR_ARRAY, CMD_ARRAY, DUMMY_ARRAY, 1'b1);
    start(MODE_SPI, 3'h0, 1'b0);
    tick(400);
    chk("reserved", {bad_q, done_q, lk.flash_select_n}, 3'h5);
    $display("test reserved done");
    start(3'h2, VAR_FAST, 1'b0);
    tick(50);
    chk("other mode", {done_q, lk.flash_select_n}, 2'h3);
    $display("test other mode done");
    give_verdict();
  end
endmodule
`default_nettype wire
